// ### rtl/dmacm_channel.sv
// Purpose: Four-channel DMA mode control and bus-cycle generation with access splitting.
// Assumes: Single clock; the bus answers each cycle with busAck, read data low aligned.
// Notes: Per-device bus width comes with each request; count and address registers are outside.
`timescale 1ns/1ps

module dmacm_channel #(
  parameter int NUM_CH     = dmacm_pkg::NUM_CH,
  parameter int FIFO_DEPTH = dmacm_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                      ref_clk,
  input  wire logic                      rst,
  // Control register load path
  input  wire logic                      ldcWrite,
  input  wire logic [$clog2(NUM_CH)-1:0] ldcChan,
  input  wire logic [31:0]               ldcWdata,
  output logic      [31:0]               ldcRdata,
  // Transfer requests
  input  wire logic                      reqValid,
  output logic                           reqReady,
  input  wire logic [$clog2(NUM_CH)-1:0] reqChan,
  input  wire logic [31:0]               reqSrcAddr,
  input  wire logic [31:0]               reqDstAddr,
  input  wire logic [1:0]                reqSrcWidth,
  input  wire logic [1:0]                reqDstWidth,
  // Internal bus master
  output logic                           busReq,
  output logic                           busWrite,
  output logic      [31:0]               busAddr,
  output logic      [2:0]                busBytes,
  output logic      [31:0]               busWdata,
  input  wire logic                      busAck,
  input  wire logic [31:0]               busRdata,
  // Transfer completion
  output logic                           doneValid,
  output logic      [$clog2(NUM_CH)-1:0] doneChan,
  output logic      [31:0]               doneSrcAddr,
  output logic      [31:0]               doneDstAddr,
  output logic                           doneRepeat,
  output logic                           busy
);
  localparam int CW = $clog2(NUM_CH);

  dmacm_pkg::dmacm_state_t state;
  dmacm_pkg::dmacm_state_t next_state;

  logic [NUM_CH-1:0][5:0] modeBits;
  logic [CW-1:0]          actCh;
  logic [2:0]             actSize;
  logic [31:0]            srcAddr;
  logic [31:0]            dstAddr;
  logic [1:0]             srcW;
  logic [1:0]             dstW;
  logic                   srcInc;
  logic                   dstInc;
  logic                   actRepeat;
  logic [31:0]            curAddr;
  logic [2:0]             remain;
  logic [2:0]             lanes;
  logic [2:0]             fillCnt;
  logic [31:0]            shReg;

  wire [1:0] chanMode;
  wire [1:0] chanSize;
  wire       chanOn;
  wire       sizeOk;
  wire       take;
  wire       wrPhase;
  wire [1:0] curW;
  wire [2:0] piece;
  wire       rdAck;
  wire       wrAck;
  wire       pushOk;
  wire       popOk;
  wire       lastLane;
  wire       lastFill;
  wire [2:0] remainLeft;

  dmacm_fifo_if #(.WIDTH(dmacm_pkg::FIFO_WIDTH)) fifo ();

  // Byte count of a transfer unit.
  function automatic logic [2:0] unit_bytes(input logic [1:0] size);
    unit_bytes = (size == dmacm_pkg::XSIZE_8)  ? 3'h1 :
                 (size == dmacm_pkg::XSIZE_16) ? 3'h2 : 3'h4;
  endfunction

  // Length of the next piece: the rest of the unit, cut at the bus width boundary.
  function automatic logic [2:0] piece_len(input logic [31:0] addr,
                                           input logic [1:0]  width,
                                           input logic [2:0]  rem);
    logic [3:0] wb;
    logic [3:0] room;
    wb   = 4'h1 << width;
    room = wb - {1'b0, addr[2:0] & (wb[2:0] - 3'h1)};
    if ({1'b0, rem} < room)
      piece_len = rem;
    else
      piece_len = room[2:0];
  endfunction

  // Mode registers, loaded only through the control register load path.
  dmacm_mode_regs #(.NUM_CH(NUM_CH)) u_mode (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .ldcWrite (ldcWrite),
    .ldcChan  (ldcChan),
    .ldcWdata (ldcWdata[5:0]),
    .modeBits (modeBits)
  );

  // Bytes fetched by source reads wait here for the destination writes.
  dmacm_fifo #(.WIDTH(dmacm_pkg::FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk (ref_clk),
    .rst     (rst),
    .fifo    (fifo.store)
  );

  // Read back the addressed channel; bits without storage return zero.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      ldcRdata <= 32'h0000_0000;
    else
      ldcRdata <= {26'h000_0000, modeBits[ldcChan]};
  end

  // Request acceptance decode for the addressed channel.
  assign chanMode = modeBits[reqChan][dmacm_pkg::MODE_LSB +: 2];
  assign chanSize = modeBits[reqChan][dmacm_pkg::SIZE_LSB +: 2];
  assign chanOn   = (chanMode == dmacm_pkg::XMODE_SINGLE) ||
                    (chanMode == dmacm_pkg::XMODE_REPEAT);
  assign sizeOk   = (chanSize != dmacm_pkg::XSIZE_BAD);
  assign reqReady = (state == dmacm_pkg::ST_IDLE) && chanOn && sizeOk;
  assign take     = reqValid && reqReady;

  // Piece sizing follows the address and the width of the bus addressed now.
  assign wrPhase    = (state == dmacm_pkg::ST_WRFIL) || (state == dmacm_pkg::ST_WRISS);
  assign curW       = wrPhase ? dstW : srcW;
  assign piece      = piece_len(curAddr, curW, remain);
  assign remainLeft = remain - piece;

  // Handshake events.
  assign rdAck    = (state == dmacm_pkg::ST_RDISS) && busAck;
  assign wrAck    = (state == dmacm_pkg::ST_WRISS) && busAck;
  assign pushOk   = fifo.wValid && fifo.wReady;
  assign popOk    = fifo.rReady && fifo.rValid;
  assign lastLane = (lanes == 3'h1);
  assign lastFill = ((fillCnt + 3'h1) == piece);

  // FIFO side: bytes leave the shift register low lane first.
  assign fifo.wValid = (state == dmacm_pkg::ST_RDPSH);
  assign fifo.wData  = shReg[7:0];
  assign fifo.rReady = (state == dmacm_pkg::ST_WRFIL);

  // Bus master outputs; address and data come straight from registers.
  assign busReq    = (state == dmacm_pkg::ST_RDISS) || (state == dmacm_pkg::ST_WRISS);
  assign busWrite  = (state == dmacm_pkg::ST_WRISS);
  assign busAddr   = curAddr;
  assign busBytes  = busReq ? piece : 3'h0;
  assign busWdata  = shReg;

  // Completion outputs.
  assign doneValid   = (state == dmacm_pkg::ST_DONE);
  assign doneChan    = actCh;
  assign doneSrcAddr = srcAddr;
  assign doneDstAddr = dstAddr;
  assign doneRepeat  = actRepeat;
  assign busy        = (state != dmacm_pkg::ST_IDLE);

  // Sequencer: all source reads of a unit, then all destination writes.
  always_comb
  begin
    next_state = state;
    case (state)
      dmacm_pkg::ST_IDLE:
        if (take)
          next_state = dmacm_pkg::ST_RDISS;
      dmacm_pkg::ST_RDISS:
        if (busAck)
          next_state = dmacm_pkg::ST_RDPSH;
      dmacm_pkg::ST_RDPSH:
        if (pushOk && lastLane)
          next_state = (remain == 3'h0) ? dmacm_pkg::ST_WRFIL
                                        : dmacm_pkg::ST_RDISS;
      dmacm_pkg::ST_WRFIL:
        if (popOk && lastFill)
          next_state = dmacm_pkg::ST_WRISS;
      dmacm_pkg::ST_WRISS:
        if (busAck)
          next_state = (remainLeft == 3'h0) ? dmacm_pkg::ST_DONE
                                            : dmacm_pkg::ST_WRFIL;
      dmacm_pkg::ST_DONE:
        next_state = dmacm_pkg::ST_IDLE;
      default:
        next_state = dmacm_pkg::ST_IDLE;
    endcase
  end

  // State register.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      state <= dmacm_pkg::ST_IDLE;
    else
      state <= next_state;
  end

  // Latch the channel setup when a request is taken, so later mode writes do not disturb it.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      actCh     <= '0;
      actSize   <= 3'h1;
      srcW      <= dmacm_pkg::BUSW_8;
      dstW      <= dmacm_pkg::BUSW_8;
      srcInc    <= 1'b0;
      dstInc    <= 1'b0;
      actRepeat <= 1'b0;
    end
    else if (take)
    begin
      actCh     <= reqChan;
      actSize   <= unit_bytes(chanSize);
      srcW      <= reqSrcWidth;
      dstW      <= reqDstWidth;
      srcInc    <= modeBits[reqChan][dmacm_pkg::SRC_INC_BIT];
      dstInc    <= modeBits[reqChan][dmacm_pkg::DST_INC_BIT];
      actRepeat <= (chanMode == dmacm_pkg::XMODE_REPEAT);
    end
  end

  // Transfer addresses; the increment is applied once the unit is written.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      srcAddr <= 32'h0000_0000;
      dstAddr <= 32'h0000_0000;
    end
    else if (take)
    begin
      srcAddr <= reqSrcAddr;
      dstAddr <= reqDstAddr;
    end
    else if (wrAck && (remainLeft == 3'h0))
    begin
      srcAddr <= srcAddr + (srcInc ? {29'h0, actSize} : 32'h0000_0000);
      dstAddr <= dstAddr + (dstInc ? {29'h0, actSize} : 32'h0000_0000);
    end
  end

  // Walking address and bytes left; each piece starts where the last one ended, except the first write, which starts at dstAddr.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      curAddr <= 32'h0000_0000;
      remain  <= 3'h0;
    end
    else if (take)
    begin
      curAddr <= reqSrcAddr;
      remain  <= unit_bytes(chanSize);
    end
    else if (rdAck || wrAck)
    begin
      curAddr <= curAddr + {29'h0, piece};
      remain  <= remainLeft;
    end
    else if (pushOk && lastLane && (remain == 3'h0))
    begin
      curAddr <= dstAddr;
      remain  <= actSize;
    end
  end

  // Lane counters for pushing read bytes and gathering write bytes.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      lanes   <= 3'h0;
      fillCnt <= 3'h0;
    end
    else
    begin
      if (rdAck)
        lanes <= piece;
      else if (pushOk)
        lanes <= lanes - 3'h1;
      if (wrAck)
        fillCnt <= 3'h0;
      else if (popOk)
        fillCnt <= lastFill ? 3'h0 : fillCnt + 3'h1;
    end
  end

  // Data shift register: read data shifts out low byte first, write data fills by lane.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      shReg <= 32'h0000_0000;
    else if (rdAck)
      shReg <= busRdata;
    else if (pushOk)
      shReg <= (lastLane && (remain == 3'h0)) ? 32'h0000_0000 : {8'h00, shReg[31:8]};
    else if (popOk)
      shReg[{fillCnt[1:0], 3'h0} +: 8] <= fifo.rData;
    else if (wrAck)
      shReg <= 32'h0000_0000;
  end

endmodule

// ### rtl/dmacm_pkg.sv
// Purpose: Shared constants and types for the DMA channel mode and bus split block.
// Assumes: Four channels, byte addressed internal buses up to 64 bits wide.
// Notes: Field positions refer to the six stored bits of each channel mode register.
package dmacm_pkg;

  // Channel count and data FIFO depth.
  localparam int NUM_CH     = 4;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_WIDTH = 8;

  // Mode register field layout.
  localparam int MODE_STORED_W = 6;
  localparam int MODE_LSB      = 0;
  localparam int SIZE_LSB      = 2;
  localparam int SRC_INC_BIT   = 4;
  localparam int DST_INC_BIT   = 5;
  localparam logic [5:0] MODE_RESET = 6'h00;

  // Transfer mode codes.
  localparam logic [1:0] XMODE_OFF    = 2'h0;
  localparam logic [1:0] XMODE_SINGLE = 2'h1;
  localparam logic [1:0] XMODE_BAD    = 2'h2;
  localparam logic [1:0] XMODE_REPEAT = 2'h3;

  // Transfer size codes.
  localparam logic [1:0] XSIZE_8   = 2'h0;
  localparam logic [1:0] XSIZE_16  = 2'h1;
  localparam logic [1:0] XSIZE_32  = 2'h2;
  localparam logic [1:0] XSIZE_BAD = 2'h3;

  // Target bus width codes, byte count is one shifted left by the code.
  localparam logic [1:0] BUSW_8  = 2'h0;
  localparam logic [1:0] BUSW_16 = 2'h1;
  localparam logic [1:0] BUSW_32 = 2'h2;
  localparam logic [1:0] BUSW_64 = 2'h3;

  // Engine states, one-hot.
  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_RDISS = 6'h02,
    ST_RDPSH = 6'h04,
    ST_WRFIL = 6'h08,
    ST_WRISS = 6'h10,
    ST_DONE  = 6'h20
  } dmacm_state_t;

endpackage

// ### rtl/dmacm_fifo_if.sv
// Purpose: Carrier for the byte stream between the transfer engine and its FIFO.
// Assumes: Valid and ready handshake on both sides, same clock.
// Notes: The engine fills and drains; the store modport is the FIFO.
`timescale 1ns/1ps
interface dmacm_fifo_if #(parameter int WIDTH = 8);
  logic             wValid;
  logic             wReady;
  logic [WIDTH-1:0] wData;
  logic             rValid;
  logic             rReady;
  logic [WIDTH-1:0] rData;

  // Engine side pushes read bytes and pops bytes to write.
  modport engine (output wValid, output wData, input wReady,
                  input rValid, input rData, output rReady);

  // Store side holds the bytes.
  modport store (input wValid, input wData, output wReady,
                 output rValid, output rData, input rReady);
endinterface

// ### rtl/dmacm_fifo.sv
// Purpose: Synchronous FIFO holding fetched bytes between source read and destination write.
// Assumes: DEPTH is a power of two.
// Notes: Full and empty come from a count; a stalled reader really fills it.
`timescale 1ns/1ps
module dmacm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic   ref_clk,
  input wire logic   rst,
  // Byte stream
  dmacm_fifo_if.store fifo
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr;
  logic [AW-1:0]    rdPtr;
  logic [AW:0]      count;
  wire              doPush;
  wire              doPop;

  // Handshake decode from the occupancy count.
  assign fifo.wReady = (count != (AW+1)'(DEPTH));
  assign fifo.rValid = (count != '0);
  assign fifo.rData  = mem[rdPtr];
  assign doPush      = fifo.wValid & fifo.wReady;
  assign doPop       = fifo.rReady & fifo.rValid;

  // Storage write.
  always_ff @(posedge ref_clk)
  begin
    if (doPush)
      mem[wrPtr] <= fifo.wData;
  end

  // Pointers and count.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end
    else
    begin
      if (doPush)
        wrPtr <= wrPtr + 1'b1;
      if (doPop)
        rdPtr <= rdPtr + 1'b1;
      if (doPush && !doPop)
        count <= count + 1'b1;
      else if (doPop && !doPush)
        count <= count - 1'b1;
    end
  end
endmodule

// ### rtl/dmacm_mode_regs.sv
// Purpose: The per-channel mode registers, written by the control register load path.
// Assumes: One write per cycle, channel picked by index.
// Notes: Only six bits per channel hold storage; upper write data is dropped.
`timescale 1ns/1ps
module dmacm_mode_regs #(
  parameter int NUM_CH = dmacm_pkg::NUM_CH
) (
  // Clock and reset
  input  wire logic                        ref_clk,
  input  wire logic                        rst,
  // Control register load path
  input  wire logic                        ldcWrite,
  input  wire logic [$clog2(NUM_CH)-1:0]   ldcChan,
  input  wire logic [5:0]                  ldcWdata,
  // Stored fields
  output logic      [NUM_CH-1:0][5:0]      modeBits
);
  genvar ch;

  // One register per channel; bits above five are not kept.
  generate
    for (ch = 0; ch < NUM_CH; ch++)
    begin : g_ch
      wire hit = ldcWrite && (ldcChan == ($clog2(NUM_CH))'(ch));
      always_ff @(posedge ref_clk)
      begin
        if (rst)
          modeBits[ch] <= dmacm_pkg::MODE_RESET;
        else if (hit)
          modeBits[ch] <= ldcWdata;
      end
    end
  endgenerate
endmodule

// ### tb/dmacm_monitor.sv
// Purpose: Concurrent checks on the mode registers and the bus split.
// Assumes: One clock, synchronous active high reset.
// Notes: Shadows the mode registers and the accepted unit to predict each piece.
`timescale 1ns/1ps
module dmacm_monitor #(
  parameter int NUM_CH = dmacm_pkg::NUM_CH
) (
  // Clock and reset
  input wire logic                      ref_clk,
  input wire logic                      rst,
  // Register path
  input wire logic                      ldcWrite,
  input wire logic [$clog2(NUM_CH)-1:0] ldcChan,
  input wire logic [31:0]               ldcWdata,
  input wire logic [31:0]               ldcRdata,
  // Requests
  input wire logic                      reqValid,
  input wire logic                      reqReady,
  input wire logic [$clog2(NUM_CH)-1:0] reqChan,
  input wire logic [31:0]               reqSrcAddr,
  input wire logic [31:0]               reqDstAddr,
  input wire logic [1:0]                reqSrcWidth,
  input wire logic [1:0]                reqDstWidth,
  // Bus and completion
  input wire logic                      busReq,
  input wire logic                      busWrite,
  input wire logic [31:0]               busAddr,
  input wire logic [2:0]                busBytes,
  input wire logic                      busAck,
  input wire logic                      doneValid,
  input wire logic [31:0]               doneSrcAddr,
  input wire logic [31:0]               doneDstAddr,
  input wire logic                      doneRepeat,
  input wire logic                      busy
);
  logic [NUM_CH-1:0][5:0] shMode;
  logic [5:0]             latMode;
  logic [1:0]             latSw;
  logic [1:0]             latDw;
  logic [31:0]            latSrc;
  logic [31:0]            latDst;
  logic [2:0]             rdCnt;
  logic [2:0]             wrCnt;

  // Predict the piece the bus should carry now and whether a channel may start.
  wire        accept   = reqValid && reqReady;
  wire [2:0]  unitB    = 3'h1 << latMode[3:2];
  wire [1:0]  curW     = busWrite ? latDw : latSw;
  wire [2:0]  doneB    = busWrite ? wrCnt : rdCnt;
  wire [3:0]  room     = (4'h1 << curW) - {1'b0, busAddr[2:0] & ((3'h1 << curW) - 3'h1)};
  wire [3:0]  left     = {1'b0, unitB - doneB};
  wire [3:0]  expBytes = (room < left) ? room : left;
  wire [5:0]  reqMode  = shMode[reqChan];
  wire [5:0]  selMode  = shMode[ldcChan];
  wire        chanOk   = reqMode[0] && reqMode[3:2] != 2'h3;
  wire [31:0] expAddr  = busWrite ? latDst + 32'(wrCnt) : latSrc + 32'(rdCnt);

  // Follow register writes, the accepted unit and the bytes moved so far.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      shMode <= '0;
      rdCnt  <= 3'h0;
      wrCnt  <= 3'h0;
    end
    else
    begin
      if (ldcWrite)
        shMode[ldcChan] <= ldcWdata[5:0];
      if (busReq && busAck && busWrite)
        wrCnt <= wrCnt + busBytes;
      if (busReq && busAck && !busWrite)
        rdCnt <= rdCnt + busBytes;
      if (accept)
      begin
        latMode <= reqMode;
        latSw   <= reqSrcWidth;
        latDw   <= reqDstWidth;
        latSrc  <= reqSrcAddr;
        latDst  <= reqDstAddr;
        rdCnt   <= 3'h0;
        wrCnt   <= 3'h0;
      end
    end
  end

  chk_reset_quiet: assert property (@(posedge ref_clk)
    rst |=> !reqReady && !busy && !busReq) else $error("Block active after reset");
  chk_ready_gate: assert property (@(posedge ref_clk) disable iff (rst)
    reqReady == (!busy && chanOk)) else $error("Request ready disagrees with mode");
  chk_readback_zero: assert property (@(posedge ref_clk) disable iff (rst)
    1'b1 |=> ldcRdata == {26'h0, $past(selMode)}) else $error("Mode readback wrong");
  chk_read_first: assert property (@(posedge ref_clk) disable iff (rst)
    accept |=> busReq && !busWrite && busAddr == $past(reqSrcAddr)) else $error("No source read");
  chk_req_steady: assert property (@(posedge ref_clk) disable iff (rst)
    busReq && !busAck |=> busReq && $stable(busAddr) && $stable(busBytes) && $stable(busWrite))
    else $error("Bus request changed before acknowledge");
  chk_piece_size: assert property (@(posedge ref_clk) disable iff (rst)
    busReq |-> {1'b0, busBytes} == expBytes) else $error("Piece length wrong");
  chk_piece_order: assert property (@(posedge ref_clk) disable iff (rst)
    busReq |-> busAddr == expAddr) else $error("Piece address out of order");
  chk_write_after: assert property (@(posedge ref_clk) disable iff (rst)
    busReq && busWrite |-> rdCnt == unitB) else $error("Write before read finished");
  chk_done_fields: assert property (@(posedge ref_clk) disable iff (rst)
    doneValid |-> doneSrcAddr == latSrc + (latMode[4] ? 32'(unitB) : 32'h0)
      && doneDstAddr == latDst + (latMode[5] ? 32'(unitB) : 32'h0)
      && doneRepeat == (latMode[1:0] == 2'h3)) else $error("Completion fields wrong");
  chk_done_timing: assert property (@(posedge ref_clk) disable iff (rst)
    busReq && busAck && busWrite && wrCnt + busBytes == unitB |=> doneValid ##1 !busy)
    else $error("Completion not on time");
endmodule

bind dmacm_channel dmacm_monitor #(.NUM_CH(NUM_CH)) i_dmacm_monitor (
  .ref_clk(ref_clk), .rst(rst), .ldcWrite(ldcWrite), .ldcChan(ldcChan),
  .ldcWdata(ldcWdata), .ldcRdata(ldcRdata), .reqValid(reqValid), .reqReady(reqReady),
  .reqChan(reqChan), .reqSrcAddr(reqSrcAddr), .reqDstAddr(reqDstAddr),
  .reqSrcWidth(reqSrcWidth), .reqDstWidth(reqDstWidth), .busReq(busReq),
  .busWrite(busWrite), .busAddr(busAddr), .busBytes(busBytes), .busAck(busAck),
  .doneValid(doneValid), .doneSrcAddr(doneSrcAddr), .doneDstAddr(doneDstAddr),
  .doneRepeat(doneRepeat), .busy(busy)
);

// ### tb/dmacm_bus_mem.sv
// Purpose: Behavioural byte memory answering the engine's internal bus.
// Assumes: Only the low eight address bits select a byte.
// Notes: Read data is valid on the acknowledge cycle only; otherwise it toggles.
`timescale 1ns/1ps
module dmacm_bus_mem (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Bus from the engine
  input  wire logic        busReq,
  input  wire logic        busWrite,
  input  wire logic [31:0] busAddr,
  input  wire logic [2:0]  busBytes,
  input  wire logic [31:0] busWdata,
  output logic             busAck,
  output logic [31:0]      busRdata,
  // Answer speed
  input  wire logic [1:0]  waitCycles
);
  logic [7:0] mem [256];
  logic [1:0] waitCnt;
  logic [7:0] idx;

  // Seed the store with a pattern that differs at every byte.
  initial
  begin
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
    busAck   = 1'b0;
    busRdata = 32'h0;
  end

  // Answer each request after the set wait; unused lanes never hold stale data.
  always @(posedge ref_clk)
  begin
    busAck   <= 1'b0;
    busRdata <= ~busRdata;
    if (rst)
      waitCnt <= 2'h0;
    else if (busReq && !busAck && waitCnt != waitCycles)
      waitCnt <= waitCnt + 2'h1;
    else if (busReq && !busAck)
    begin
      waitCnt <= 2'h0;
      busAck  <= 1'b1;
      for (int i = 0; i < 4; i++)
      begin
        idx = busAddr[7:0] + 8'(i);
        busRdata[8*i +: 8] <= (i < busBytes) ? mem[idx] : ~busRdata[8*i +: 8];
        if (busWrite && i < busBytes) mem[idx] <= busWdata[8*i +: 8];
      end
    end
  end
endmodule

// ### tb/tb.sv
// Purpose: Self-checking bench for the DMA mode control and bus split block.
// Assumes: Inputs change one nanosecond after the rising clock edge.
// Notes: Sweeps every size, bus width and byte offset through one memory model.
`timescale 1ns/1ps
module tb;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        ldcWrite = 1'b0;
  logic [1:0]  ldcChan = 2'h0;
  logic [31:0] ldcWdata = 32'h0;
  logic        reqValid = 1'b0;
  logic [1:0]  reqChan = 2'h0;
  logic [31:0] reqSrcAddr = 32'h0;
  logic [31:0] reqDstAddr = 32'h0;
  logic [1:0]  reqSrcWidth = 2'h0;
  logic [1:0]  reqDstWidth = 2'h0;
  logic [1:0]  waitCycles = 2'h0;
  logic        reqReady, busReq, busWrite, busAck, doneValid, doneRepeat, busy;
  logic [31:0] ldcRdata, busAddr, busWdata, busRdata, doneSrcAddr, doneDstAddr;
  logic [2:0]  busBytes;
  logic [1:0]  doneChan;
  logic [5:0]  badMode [3] = '{6'h00, 6'h02, 6'h0d};
  int          num_errors = 0;
  int          cmp_count = 0;
  int          nRd = 0;
  int          nWr = 0;

  always #5 ref_clk = ~ref_clk;

  dmacm_channel i_dmacm_channel (
    .ref_clk(ref_clk), .rst(rst), .ldcWrite(ldcWrite), .ldcChan(ldcChan),
    .ldcWdata(ldcWdata), .ldcRdata(ldcRdata), .reqValid(reqValid), .reqReady(reqReady),
    .reqChan(reqChan), .reqSrcAddr(reqSrcAddr), .reqDstAddr(reqDstAddr),
    .reqSrcWidth(reqSrcWidth), .reqDstWidth(reqDstWidth), .busReq(busReq),
    .busWrite(busWrite), .busAddr(busAddr), .busBytes(busBytes), .busWdata(busWdata),
    .busAck(busAck), .busRdata(busRdata), .doneValid(doneValid), .doneChan(doneChan),
    .doneSrcAddr(doneSrcAddr), .doneDstAddr(doneDstAddr), .doneRepeat(doneRepeat),
    .busy(busy));

  dmacm_bus_mem i_dmacm_bus_mem (
    .ref_clk(ref_clk), .rst(rst), .busReq(busReq), .busWrite(busWrite), .busAddr(busAddr),
    .busBytes(busBytes), .busWdata(busWdata), .busAck(busAck), .busRdata(busRdata),
    .waitCycles(waitCycles));

  // Count the pieces the bus completes in each direction.
  always @(posedge ref_clk)
  begin
    if (busReq && busAck && busWrite) nWr <= nWr + 1;
    if (busReq && busAck && !busWrite) nRd <= nRd + 1;
  end

  task automatic complete_run();
    if (num_errors == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Pieces needed when each one stops at the next bus width boundary.
  function automatic int npieces(input int a, input int n, input int w);
    int c;
    int s;
    c = 0;
    while (n > 0)
    begin
      s = (1 << w) - (a % (1 << w));
      if (s > n) s = n;
      a += s;
      n -= s;
      c++;
    end
    return c;
  endfunction

  // Write one mode register, then read it straight back.
  task automatic control_register_load_instr(input logic [1:0] ch, input logic [31:0] data);
    ldcWrite = 1'b1;
    ldcChan  = ch;
    ldcWdata = data;
    @(posedge ref_clk);
    #1 ldcWrite = 1'b0;
    @(posedge ref_clk);
    #1 check(ldcRdata, {26'h0, data[5:0]});
  endtask

  // Program a channel, run one unit and compare every visible effect.
  task automatic xfer(input logic [1:0] ch, sz, sw, dw, input logic [7:0] sa, da,
                      input logic si, di, rp);
    logic [7:0] want [4];
    int         n;
    int         k;
    n = 1 << sz;
    for (k = 0; k < n; k++) want[k] = i_dmacm_bus_mem.mem[8'(sa + k)];
    control_register_load_instr(ch, 32'h0);
    control_register_load_instr(ch, {26'h0, di, si, sz, 2'h0});
    control_register_load_instr(ch, {26'h0, di, si, sz, rp, 1'b1});
    nRd         = 0;
    nWr         = 0;
    reqChan     = ch;
    reqSrcAddr  = {24'h0, sa};
    reqDstAddr  = {24'h0, da};
    reqSrcWidth = sw;
    reqDstWidth = dw;
    reqValid    = 1'b1;
    #1 check(reqReady, 1'b1);
    @(posedge ref_clk);
    #1 reqValid = 1'b0;
    k = 0;
    while (doneValid !== 1'b1 && k < 100)
    begin
      @(posedge ref_clk);
      #1 k++;
    end
    check(k < 100, 1'b1);
    check(doneChan, ch);
    check(doneSrcAddr, reqSrcAddr + (si ? n : 0));
    check(doneDstAddr, reqDstAddr + (di ? n : 0));
    check(doneRepeat, rp);
    check(nRd, npieces(sa, n, sw));
    check(nWr, npieces(da, n, dw));
    for (k = 0; k < n; k++) check(i_dmacm_bus_mem.mem[8'(da + k)], want[k]);
    @(posedge ref_clk);
    #1 check(busy, 1'b0);
  endtask

  // Main sequence: reset, readback, refused modes, then the full sweep.
  initial
  begin
    repeat (20) @(posedge ref_clk);
    #1 rst = 1'b0;
    check(ldcRdata, 32'h0);
    control_register_load_instr(2'h1, 32'hffff_ffd5);
    reqChan  = 2'h2;
    reqValid = 1'b1;
    foreach (badMode[m])
    begin
      control_register_load_instr(2'h2, {26'h0, badMode[m]});
      check({busy, reqReady}, 2'h0);
    end
    reqValid = 1'b0;
    for (int s = 0; s < 3; s++)
      for (int w = 0; w < 4; w++)
        for (int o = 0; o < 8; o++)
        begin
          waitCycles = 2'(o);
          xfer(2'(o), 2'(s), 2'(w), 2'(w + 1), 8'h10 + 8'(o), 8'h80 + 8'(o ^ 3),
               o[0], o[1], w[0]);
        end
    complete_run();
  end

  // Cut a hang short well past the expected run length.
  initial
  begin
    #200000;
    num_errors++;
    complete_run();
  end
endmodule
